// File: rtl/msbs_pkg.sv
// Summary of operation
// - Supply below undervoltage threshold disables power stage and raises error.
// - Error clears itself once supply exceeds threshold plus 1.5 V.
// - Reduction starts only after programmed standstill idle time in ms.
// - Reduction acts only with config bit 3 set and motor stationary.
// - Setting zero or positive below rated current sets rms current in mA.
// - Setting -1 to -100 gives rated times (setting plus 100) over 100.
// - At standstill wait close-brake idle time, then engage brake.
// - After engaging brake wait shutdown idle time, then current off.
// - Power-up switches current on, waits open delay, then releases brake.
// - After release wait start delay before operation enabled is allowed.
// - Brake output is PWM, frequency in Hz, settings 0 to 2000.
// - Brake duty in percent, settings 0 or 2 to 100.
// - Currents published in mA as signed peak, root two times rms.
// - Readout 1 field-forming, readout 2 torque-forming, signed 32 bit.
// - Readout 3 phase A or U, readout 4 phase B or W.
// - Field and torque readouts live only in closed loop, else zero.
package msbs_pkg;
  localparam logic [15:0] OBJ_UV       = 16'h2035;
  localparam logic [15:0] OBJ_RED_IDLE = 16'h2036;
  localparam logic [15:0] OBJ_RED_VAL  = 16'h2037;
  localparam logic [15:0] OBJ_BRAKE    = 16'h2038;
  localparam logic [15:0] OBJ_CUR      = 16'h2039;
  localparam logic [7:0]  SUB_CLOSE    = 8'h01;
  localparam logic [7:0]  SUB_SHUT     = 8'h02;
  localparam logic [7:0]  SUB_OPEN     = 8'h03;
  localparam logic [7:0]  SUB_START    = 8'h04;
  localparam logic [7:0]  SUB_FREQ     = 8'h05;
  localparam logic [7:0]  SUB_DUTY     = 8'h06;
  localparam logic [7:0]  SUB_NONE     = 8'h00;
  localparam logic [31:0] RST_UV       = 32'h00002710;
  localparam logic [31:0] RST_IDLE     = 32'h000003e8;
  localparam logic [31:0] RST_RED      = 32'h0fffffce;
  localparam logic [31:0] RST_BRK_T    = 32'h000003e8;
  localparam logic [31:0] RST_ZERO     = 32'h00000000;
  localparam logic [31:0] UV_HYST_MV   = 32'h000005dc;
  localparam logic [31:0] PWM_FMAX     = 32'h000007d0;
  localparam logic [31:0] DUTY_MIN     = 32'h00000002;
  localparam logic [31:0] DUTY_MAX     = 32'h00000064;
  localparam logic [6:0]  PCT_LAST     = 7'h63;
  localparam logic signed [31:0] PCT_LOW = -32'sh64;
  localparam int          RED_EN_BIT   = 3;
  localparam int          CLK_HZ       = 40_000_000;
  localparam int          CLK_NS       = 25;
  localparam int          MS_NS        = 1_000_000;
  localparam int          MS_CYC       = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [17:0] PEAK_K       = 18'h0b505;
  localparam int          PEAK_SH      = 15;
  typedef enum logic [2:0] {
    ST_OFF        = 3'h0,
    ST_OPEN_WAIT  = 3'h1,
    ST_START_WAIT = 3'h2,
    ST_RUN        = 3'h3,
    ST_STOP_WAIT  = 3'h4,
    ST_CLOSE_WAIT = 3'h5,
    ST_SHUT_WAIT  = 3'h6
  } msbs_state_t;
endpackage : msbs_pkg

// File: rtl/msbs_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module msbs_supervisor
  import msbs_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  input  wire logic               obj_req,
  input  wire logic               obj_wr,
  input  wire logic [15:0]        obj_index,
  input  wire logic [7:0]         obj_sub,
  input  wire logic [31:0]        obj_wdata,
  output logic                    obj_ack_r,
  output logic                    obj_err_r,
  output logic [31:0]             obj_rdata_r,
  input  wire logic [31:0]        supply_mv,
  input  wire logic               standstill,
  input  wire logic               power_req,
  input  wire logic               closed_loop,
  input  wire logic [31:0]        motor_drive_config,
  input  wire logic [31:0]        rated_motor_current,
  input  wire logic               meas_valid,
  input  wire logic signed [31:0] meas_rms [4],
  output logic                    power_stage_en_r,
  output logic                    uv_err_r,
  output logic                    brake_pwm_r,
  output logic                    op_enable_ok_r,
  output logic                    reduce_active_r,
  output logic [31:0]             current_limit_r
);
  logic [31:0] uv_thr_r, red_idle_r, red_val_r, brk_r [4], pwm_freq_r, pwm_duty_r;
  logic signed [31:0] cur_r [4];
  msbs_state_t st_r, st_nxt;
  logic [31:0] ms_pre_r, ms_cnt_r, red_pre_r, red_ms_r;
  logic [25:0] pwm_acc_r;
  logic [6:0]  pwm_pct_r;
  logic        wr_go, step_done, red_cond, uv_nxt;
  logic [31:0] lim_nxt;

  assign wr_go = clk_en && obj_req && obj_wr;

  // Unknown object, read-only object and out-of-range values all answer err
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      uv_thr_r   <= RST_UV;
      red_idle_r <= RST_IDLE;
      red_val_r  <= RST_RED;
      brk_r[0]   <= RST_BRK_T;
      brk_r[1]   <= RST_BRK_T;
      brk_r[2]   <= RST_BRK_T;
      brk_r[3]   <= RST_ZERO;
      pwm_freq_r <= RST_ZERO;
      pwm_duty_r <= RST_ZERO;
    end else if (wr_go) begin
      unique case (obj_index)
        OBJ_UV:       if (obj_sub == SUB_NONE) uv_thr_r <= obj_wdata;
        OBJ_RED_IDLE: if (obj_sub == SUB_NONE) red_idle_r <= obj_wdata;
        OBJ_RED_VAL:  if (obj_sub == SUB_NONE) red_val_r <= obj_wdata;
        OBJ_BRAKE: begin
          if (obj_sub >= SUB_CLOSE && obj_sub <= SUB_START)
            brk_r[obj_sub[1:0] - 2'h1] <= obj_wdata;
          if (obj_sub == SUB_FREQ && obj_wdata <= PWM_FMAX)
            pwm_freq_r <= obj_wdata;
          if (obj_sub == SUB_DUTY && (obj_wdata == RST_ZERO ||
              (obj_wdata >= DUTY_MIN && obj_wdata <= DUTY_MAX)))
            pwm_duty_r <= obj_wdata;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      obj_ack_r   <= 1'b0;
      obj_err_r   <= 1'b0;
      obj_rdata_r <= RST_ZERO;
    end else if (clk_en) begin
      obj_ack_r   <= obj_req;
      obj_err_r   <= 1'b0;
      obj_rdata_r <= RST_ZERO;
      if (obj_req) begin
        unique case (obj_index)
          OBJ_UV:       obj_rdata_r <= uv_thr_r;
          OBJ_RED_IDLE: obj_rdata_r <= red_idle_r;
          OBJ_RED_VAL:  obj_rdata_r <= red_val_r;
          OBJ_BRAKE: begin
            if (obj_sub >= SUB_CLOSE && obj_sub <= SUB_START)
              obj_rdata_r <= brk_r[obj_sub[1:0] - 2'h1];
            else if (obj_sub == SUB_FREQ)
              obj_rdata_r <= pwm_freq_r;
            else if (obj_sub == SUB_DUTY)
              obj_rdata_r <= pwm_duty_r;
            obj_err_r <= obj_sub < SUB_CLOSE || obj_sub > SUB_DUTY ||
              (obj_wr && obj_sub == SUB_FREQ && obj_wdata > PWM_FMAX) ||
              (obj_wr && obj_sub == SUB_DUTY && !(obj_wdata == RST_ZERO ||
               (obj_wdata >= DUTY_MIN && obj_wdata <= DUTY_MAX)));
          end
          OBJ_CUR: begin
            if (obj_sub >= SUB_CLOSE && obj_sub <= SUB_START)
              obj_rdata_r <= cur_r[obj_sub[1:0] - 2'h1];
            obj_err_r <= obj_wr || obj_sub < SUB_CLOSE || obj_sub > SUB_START;
          end
          default: obj_err_r <= 1'b1;
        endcase
        if ((obj_index == OBJ_UV || obj_index == OBJ_RED_IDLE ||
             obj_index == OBJ_RED_VAL) && obj_sub != SUB_NONE)
          obj_err_r <= 1'b1;
      end
    end
  end

  // Undervoltage with hysteresis; between the two levels the flag holds
  always_comb begin
    uv_nxt = uv_err_r;
    if (supply_mv < uv_thr_r)
      uv_nxt = 1'b1;
    else if (supply_mv > uv_thr_r + UV_HYST_MV)
      uv_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      uv_err_r <= 1'b0;
    else if (clk_en)
      uv_err_r <= uv_nxt;
  end

  // Shared millisecond timer, restarted on every state change
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ms_pre_r <= RST_ZERO;
      ms_cnt_r <= RST_ZERO;
    end else if (clk_en) begin
      if (st_nxt != st_r) begin
        ms_pre_r <= RST_ZERO;
        ms_cnt_r <= RST_ZERO;
      end else if (ms_pre_r == 32'(MS_CYCLES - 1)) begin
        ms_pre_r <= RST_ZERO;
        if (ms_cnt_r != 32'hffffffff)
          ms_cnt_r <= ms_cnt_r + 32'h1;
      end else begin
        ms_pre_r <= ms_pre_r + 32'h1;
      end
    end
  end

  always_comb begin
    unique case (st_r)
      ST_OPEN_WAIT:  step_done = ms_cnt_r >= brk_r[2];
      ST_START_WAIT: step_done = ms_cnt_r >= brk_r[3];
      ST_CLOSE_WAIT: step_done = ms_cnt_r >= brk_r[0];
      ST_SHUT_WAIT:  step_done = ms_cnt_r >= brk_r[1];
      default:       step_done = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_OFF:        if (power_req) st_nxt = ST_OPEN_WAIT;
      ST_OPEN_WAIT:
        if (!power_req) st_nxt = ST_SHUT_WAIT;
        else if (step_done) st_nxt = ST_START_WAIT;
      ST_START_WAIT:
        if (!power_req) st_nxt = ST_STOP_WAIT;
        else if (step_done) st_nxt = ST_RUN;
      ST_RUN:        if (!power_req) st_nxt = ST_STOP_WAIT;
      ST_STOP_WAIT:
        if (power_req) st_nxt = ST_OPEN_WAIT;
        else if (standstill) st_nxt = ST_CLOSE_WAIT;
      ST_CLOSE_WAIT:
        if (power_req) st_nxt = ST_OPEN_WAIT;
        else if (!standstill) st_nxt = ST_STOP_WAIT;
        else if (step_done) st_nxt = ST_SHUT_WAIT;
      ST_SHUT_WAIT:
        if (power_req) st_nxt = ST_OPEN_WAIT;
        else if (step_done) st_nxt = ST_OFF;
      default:       st_nxt = ST_OFF;
    endcase
    if (uv_nxt)
      st_nxt = ST_OFF;
  end

  // Outputs follow the next state so they move with the state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r             <= ST_OFF;
      power_stage_en_r <= 1'b0;
      op_enable_ok_r   <= 1'b0;
    end else if (clk_en) begin
      st_r             <= st_nxt;
      power_stage_en_r <= st_nxt != ST_OFF;
      op_enable_ok_r   <= st_nxt == ST_RUN;
    end
  end

  // Brake PWM: phase accumulator steps a 0..99 percent counter at f*100 Hz
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwm_acc_r   <= 26'h0;
      pwm_pct_r   <= 7'h0;
      brake_pwm_r <= 1'b0;
    end else if (clk_en) begin
      if (pwm_acc_r + 26'(pwm_freq_r * 32'd100) >= 26'(CLK_HZ)) begin
        pwm_acc_r <= pwm_acc_r + 26'(pwm_freq_r * 32'd100) - 26'(CLK_HZ);
        pwm_pct_r <= (pwm_pct_r == PCT_LAST) ? 7'h0 : pwm_pct_r + 7'h1;
      end else begin
        pwm_acc_r <= pwm_acc_r + 26'(pwm_freq_r * 32'd100);
      end
      // Frequency or duty of zero leaves the brake coil on steadily
      brake_pwm_r <= (st_nxt == ST_START_WAIT || st_nxt == ST_RUN ||
                      st_nxt == ST_STOP_WAIT || st_nxt == ST_CLOSE_WAIT) &&
                     (pwm_freq_r == RST_ZERO || pwm_duty_r == RST_ZERO ||
                      32'(pwm_pct_r) < pwm_duty_r);
    end
  end

  // Standstill reduction
  assign red_cond = standstill && motor_drive_config[RED_EN_BIT];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      red_pre_r <= RST_ZERO;
      red_ms_r  <= RST_ZERO;
    end else if (clk_en) begin
      if (!red_cond) begin
        red_pre_r <= RST_ZERO;
        red_ms_r  <= RST_ZERO;
      end else if (red_pre_r == 32'(MS_CYCLES - 1)) begin
        red_pre_r <= RST_ZERO;
        if (red_ms_r != 32'hffffffff)
          red_ms_r <= red_ms_r + 32'h1;
      end else begin
        red_pre_r <= red_pre_r + 32'h1;
      end
    end
  end

  always_comb begin
    lim_nxt = rated_motor_current;
    if (red_cond && red_ms_r >= red_idle_r) begin
      if (!red_val_r[31] && red_val_r < rated_motor_current)
        lim_nxt = red_val_r;
      else if (red_val_r[31] && $signed(red_val_r) >= PCT_LOW)
        lim_nxt = 32'((64'(rated_motor_current) *
                  64'($signed(red_val_r) - PCT_LOW)) / 64'd100);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      current_limit_r <= RST_ZERO;
      reduce_active_r <= 1'b0;
    end else if (clk_en) begin
      current_limit_r <= lim_nxt;
      reduce_active_r <= red_cond && red_ms_r >= red_idle_r;
    end
  end

  // Current readouts, rms scaled to peak by root two in Q15
  for (genvar g = 0; g < 4; g++) begin : g_cur
    logic signed [49:0] prod;
    assign prod = meas_rms[g] * $signed({1'b0, PEAK_K});
    always_ff @(posedge sys_clk) begin
      if (!rst_n)
        cur_r[g] <= RST_ZERO;
      else if (clk_en && g < 2 && !closed_loop)
        cur_r[g] <= RST_ZERO;
      else if (clk_en && meas_valid)
        cur_r[g] <= 32'(prod >>> PEAK_SH);
    end
  end

  property p_uv_off;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && supply_mv < uv_thr_r |=> uv_err_r && !power_stage_en_r;
  endproperty
  chk_uv_power_off: assert property (p_uv_off)
    else $error("undervoltage did not cut power");

  chk_uv_hyst_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && uv_err_r && supply_mv <= uv_thr_r + UV_HYST_MV |=> uv_err_r)
    else $error("undervoltage cleared inside hysteresis");

  chk_red_idle_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && red_ms_r < red_idle_r |=> !reduce_active_r)
    else $error("reduction before idle time");

  chk_red_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !motor_drive_config[RED_EN_BIT] |=> !reduce_active_r)
    else $error("reduction without enable bit");

  chk_brake_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(brake_pwm_r) && pwm_freq_r == RST_ZERO |-> $past(power_stage_en_r))
    else $error("brake released before current on");

  chk_op_after_rel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(op_enable_ok_r) |-> $past(st_r) == ST_START_WAIT && ms_cnt_r == RST_ZERO)
    else $error("operation enabled out of order");

  chk_shut_timing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(power_stage_en_r) && !uv_err_r |-> $past(st_r) == ST_SHUT_WAIT &&
      $past(ms_cnt_r) >= brk_r[1])
    else $error("current off before shutdown idle time");

  chk_dq_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !closed_loop |=> cur_r[0] == RST_ZERO && cur_r[1] == RST_ZERO)
    else $error("field or torque readout live in open loop");

  chk_duty_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pwm_duty_r == RST_ZERO || (pwm_duty_r >= DUTY_MIN && pwm_duty_r <= DUTY_MAX))
    else $error("duty setting out of range");

  cov_uv_recover: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(uv_err_r));
  cov_run_reached: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(op_enable_ok_r));
  cov_restart: cover property (@(posedge sys_clk) disable iff (!rst_n)
    st_r == ST_SHUT_WAIT && st_nxt == ST_OPEN_WAIT);
  cov_reduce: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(reduce_active_r));
endmodule : msbs_supervisor
`default_nettype wire

// File: verif/msbs_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module msbs_motor_model (
  input  wire logic               sys_clk,
  input  wire logic               pwr_on,
  input  wire logic               move,
  input  wire logic signed [31:0] amp,
  output logic                    standstill,
  output logic                    meas_valid,
  output logic signed [31:0]      meas_rms [4]
);
  logic [2:0] tick_r = 3'h0;
  assign standstill = !move;
  // Dead windings read zero, so a missed power-off shows up in the readouts
  always_ff @(posedge sys_clk) begin
    tick_r      <= tick_r + 3'h1;
    meas_valid  <= (tick_r == 3'h7);
    meas_rms[0] <= pwr_on ? amp : 32'sh0;
    meas_rms[1] <= pwr_on ? -amp : 32'sh0;
    meas_rms[2] <= pwr_on ? amp >>> 1 : 32'sh0;
    meas_rms[3] <= pwr_on ? amp + 32'sh1 : 32'sh0;
  end
endmodule : msbs_motor_model
`default_nettype wire

// File: verif/msbs_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module msbs_supervisor_tb_top;
  import msbs_pkg::*;
  localparam int MSC = 4;
  logic               sys_clk, rst_n, clk_en, obj_req, obj_wr, closed_loop, power_req;
  logic               move, meas_valid, standstill, ack, err, pwr, uv, brake, op_ok, red;
  logic [15:0]        obj_index;
  logic [7:0]         obj_sub;
  logic [31:0]        obj_wdata, supply_mv, cfg, rated, rdata, limit;
  logic signed [31:0] amp;
  logic signed [31:0] meas_rms [4];
  logic [31:0]        mdl [int];
  logic [55:0]        wtab [13];
  int                 num_errors, checks, n, hi, rs;
  int                 rset [5];

  msbs_supervisor #(.MS_CYCLES(MSC)) i_msbs_supervisor (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .obj_req(obj_req),
    .obj_wr(obj_wr), .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata),
    .obj_ack_r(ack), .obj_err_r(err), .obj_rdata_r(rdata), .supply_mv(supply_mv),
    .standstill(standstill), .power_req(power_req), .closed_loop(closed_loop),
    .motor_drive_config(cfg), .rated_motor_current(rated), .meas_valid(meas_valid),
    .meas_rms(meas_rms), .power_stage_en_r(pwr), .uv_err_r(uv), .brake_pwm_r(brake),
    .op_enable_ok_r(op_ok), .reduce_active_r(red), .current_limit_r(limit));
  msbs_motor_model i_msbs_motor_model (
    .sys_clk(sys_clk), .pwr_on(pwr), .move(move), .amp(amp), .standstill(standstill),
    .meas_valid(meas_valid), .meas_rms(meas_rms));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic int key(input int i, input int s);
    return i * 256 + s;
  endfunction : key
  function automatic logic [31:0] peak(input logic signed [31:0] x);
    longint p;
    p = (longint'(x) * 46341) >>> 15;
    return p[31:0];
  endfunction : peak
  function automatic int red_exp(input int s, input int r);
    if (s >= 0 && s < r) return s;
    if (s <= -1 && s >= -100) return r * (s + 100) / 100;
    return r;
  endfunction : red_exp
  function automatic logic sig(input int s);
    case (s)
      0: return pwr;
      1: return brake;
      2: return op_ok;
      3: return uv;
      default: return red;
    endcase
  endfunction : sig

  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmp_rng(input string nm, input int lo, input int hi_b, input int g);
    checks++;
    if (g < lo || g > hi_b) begin
      num_errors++;
      $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi_b, g);
    end
  endtask : cmp_rng
  // Bounded so a stuck sequencer ends the run instead of hanging it
  task automatic wt(input int s, input logic v, output int k);
    k = 0;
    while (sig(s) !== v) begin
      @(negedge sys_clk);
      k++;
      if (k > 60) begin
        num_errors++;
        $display("unexpected wait %0d exp %0b got %0b", s, v, sig(s));
        close_out();
      end
    end
  endtask : wt
  task automatic obj(input logic w, input int i, input int s, input logic [31:0] d);
    @(negedge sys_clk);
    obj_req = 1'b1;
    obj_wr = w;
    obj_index = 16'(i);
    obj_sub = 8'(s);
    obj_wdata = d;
    @(negedge sys_clk);
    obj_req = 1'b0;
    cmp("ack", 32'h1, 32'(ack));
  endtask : obj
  task automatic wr_chk(input int i, input int s, input logic [31:0] d);
    logic ok;
    ok = mdl.exists(key(i, s)) && i != 'h2039;
    if (i == 'h2038 && s == 5 && d > 2000) ok = 1'b0;
    if (i == 'h2038 && s == 6 && (d == 1 || d > 100)) ok = 1'b0;
    obj(1'b1, i, s, d);
    cmp("wr err", 32'(!ok), 32'(err));
    if (ok) mdl[key(i, s)] = d;
  endtask : wr_chk
  task automatic rd_chk(input int i, input int s);
    obj(1'b0, i, s, 32'h0);
    cmp("rd err", 32'(!mdl.exists(key(i, s))), 32'(err));
    if (mdl.exists(key(i, s))) cmp("rdata", mdl[key(i, s)], rdata);
  endtask : rd_chk

  initial begin
    {rst_n, obj_req, obj_wr, power_req, closed_loop, obj_index, obj_sub} = '0;
    {clk_en, move, supply_mv, cfg, amp, obj_wdata} = {2'b11, 32'd24000, 96'h0};
    num_errors = 0;
    checks = 0;
    rs = $urandom(32'h670b);
    rated = 32'(1000 + $urandom_range(3000));
    mdl[key('h2035, 0)] = 32'h2710;
    mdl[key('h2036, 0)] = 32'h3e8;
    mdl[key('h2037, 0)] = 32'h0fffffce;
    for (int s = 1; s <= 6; s++) mdl[key('h2038, s)] = (s < 4) ? 32'h3e8 : 32'h0;
    for (int s = 1; s <= 4; s++) mdl[key('h2039, s)] = 32'h0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (mdl[k]) rd_chk(k / 256, k % 256);
    rd_chk('h2040, 0);
    rd_chk('h2038, 7);
    $display("test reset done");
    wtab = '{56'h2038_05_000007d0, 56'h2038_05_000007d1, 56'h2038_06_00000001,
             56'h2038_06_00000065, 56'h2038_06_00000002, 56'h2038_06_00000064,
             56'h2039_01_00000005, 56'h2036_00_00000002, 56'h2038_01_00000001,
             56'h2038_02_00000002, 56'h2038_03_00000002, 56'h2038_04_00000001,
             56'h2035_00_00001388};
    foreach (wtab[j]) wr_chk(wtab[j][55:40], wtab[j][39:32], wtab[j][31:0]);
    wr_chk('h2038, 5, 32'($urandom_range(2000)));
    wr_chk('h2038, 5, 32'h0);
    wr_chk('h2035, 0, 32'(5000 + $urandom_range(15000)));
    foreach (mdl[k]) rd_chk(k / 256, k % 256);
    $display("test objects done");
    power_req = 1'b1;
    wt(0, 1'b1, n);
    cmp_rng("power on", 1, 1, n);
    clk_en = 1'b0;
    repeat (20) @(negedge sys_clk);
    cmp("frozen brake", 32'h0, 32'(brake));
    cmp("frozen power", 32'h1, 32'(pwr));
    clk_en = 1'b1;
    wt(1, 1'b1, n);
    cmp_rng("brake open", 8, 12, n);
    cmp("power at open", 32'h1, 32'(pwr));
    wt(2, 1'b1, n);
    cmp_rng("op enable", 4, 8, n);
    hi = 0;
    repeat (20) @(negedge sys_clk) hi += int'(brake);
    cmp_rng("brake steady", 20, 20, hi);
    wr_chk('h2038, 5, 32'h7d0);
    wr_chk('h2038, 6, 32'h32);
    hi = 0;
    repeat (20000) @(negedge sys_clk) hi += int'(brake);
    cmp_rng("brake duty", 9900, 10100, hi);
    wr_chk('h2038, 5, 32'h0);
    amp = 32'($urandom_range(20000));
    for (int c = 0; c < 2; c++) begin
      closed_loop = c[0];
      repeat (10) @(negedge sys_clk);
      mdl[key('h2039, 1)] = c ? peak(amp) : 32'h0;
      mdl[key('h2039, 2)] = c ? peak(-amp) : 32'h0;
      mdl[key('h2039, 3)] = peak(amp >>> 1);
      mdl[key('h2039, 4)] = peak(amp + 1);
      for (int s = 1; s <= 4; s++) rd_chk('h2039, s);
    end
    supply_mv = mdl[key('h2035, 0)] - 32'h1;
    wt(3, 1'b1, n);
    cmp_rng("uv set", 1, 1, n);
    cmp("uv power", 32'h0, 32'(pwr));
    supply_mv = mdl[key('h2035, 0)] + 32'd1500;
    repeat (5) @(negedge sys_clk);
    cmp("uv held", 32'h1, 32'(uv));
    supply_mv = supply_mv + 32'h1;
    wt(3, 1'b0, n);
    cmp_rng("uv clear", 1, 1, n);
    wt(2, 1'b1, n);
    $display("test power up done");
    power_req = 1'b0;
    repeat (20) @(negedge sys_clk);
    cmp("brake moving", 32'h1, 32'(brake));
    move = 1'b0;
    wt(1, 1'b0, n);
    cmp_rng("brake close", 4, 8, n);
    cmp("power at close", 32'h1, 32'(pwr));
    wt(0, 1'b0, n);
    cmp_rng("power off", 8, 12, n);
    power_req = 1'b1;
    wt(2, 1'b1, n);
    power_req = 1'b0;
    wt(1, 1'b0, n);
    power_req = 1'b1;
    wt(1, 1'b1, n);
    cmp_rng("restart open", 8, 12, n);
    cmp("restart power", 32'h1, 32'(pwr));
    power_req = 1'b0;
    wt(0, 1'b0, n);
    $display("test brake done");
    rset = '{300, -60, -100, -101, 0};
    rset[4] = int'(rated);
    for (int j = 0; j < 5; j++) begin
      move = 1'b1;
      wr_chk('h2037, 0, 32'(rset[j]));
      cmp("moving limit", rated, limit);
      cfg = 32'h8;
      move = 1'b0;
      wt(4, 1'b1, n);
      cmp_rng("reduce delay", 8, 12, n);
      repeat (2) @(negedge sys_clk);
      cmp("reduced", 32'(red_exp(rset[j], int'(rated))), limit);
    end
    cfg = 32'hfffffff7;
    repeat (20) @(negedge sys_clk);
    cmp("no reduce", 32'h0, 32'(red));
    $display("test reduction done");
    close_out();
  end
endmodule : msbs_supervisor_tb_top
`default_nettype wire
